// ===== rtl/disk_status_report.sv
`timescale 1ns/1ns
// Summary of operation
// - Cache word bits 0-4: interrupts, cache modes.
// - Bits 5-7: used, hit, installed; else diagnostic.
// - Hit ratio BCD, 100 is a0, defect bc.
// - Scan flags bits 4-7, displacement bits 8-15.
// - Word 8 holds last command block address.
// - 21-bit address split words 9-10, ECC priority.
// - Word 11 holds sense bytes one and two.
// - Sense byte one bits 0-4 servo condition.
// - Sense byte one bits 5-7 crossing, interrupt.
// - Word 12 holds sense three and wrap.
// - Sense byte three fault and unseated bits.
// - Word 12 detail bits under timeout, interface.
// - Word 13: failure path, pages, modifier.
// - Code returned as even, carry, overflow.
// - Code values carry their fixed meanings.
// - Lowest applicable code wins.
// - Codes limited per command class; rejected requests are not limited and may get any applicable code.
// - Busy from accept until interrupt accepted; an accepted device reset also frees the unit.
// - Odd address or bad command rejected.
// - Read command returns the identifier word.
// - Controller busy gives code six.
// - Interrupt codes combine attention and ending.
module disk_status_report
   import disk_status_pkg::*;
#(
   parameter logic [15:0] DEVICE_ID = 16'h0a5c  // Arbitrary identifier value.
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Operate I/O request and answer.
   input wire operate_req_s operate_i,
   input wire logic [3:0] unit_reset_pending_i,
   input wire logic controller_busy_i,
   output logic cc_valid_o,
   output logic [2:0] condition_code_o,
   output logic [15:0] immediate_data_o,
   output logic fetch_block_o,
   // Command completion and interrupts.
   input wire logic op_done_i,
   input wire logic op_exception_i,
   input wire logic op_not_ready_i,
   input wire logic interrupt_ack_i,
   input wire logic ipl_done_i,
   output logic interrupt_req_o,
   output logic [1:0] interrupt_unit_o,
   output logic [2:0] interrupt_cc_o,
   output logic [3:0] unit_busy_o,
   // Status sources.
   input wire cache_scan_s cache_scan_i,
   input wire record_event_s record_i,
   input wire diag_event_s diag_i,
   input wire logic block_used_i,
   input wire logic [15:0] block_used_addr_i,
   // Status word read port.
   input wire logic [3:0] status_index_i,
   output logic [15:0] status_word_o
);

   // ------------------------------------------------------------
   // State.
   // ------------------------------------------------------------
   typedef struct packed {
      unit_state_e [3:0] unit;
      logic [3:0] not_ready_end;
      logic [3:0] ready_seen;
      logic ipl_armed;
      logic cc_valid;
      logic [2:0] cc;
      logic [15:0] imm_data;
      logic fetch;
      logic active;
      logic [1:0] active_unit;
      logic irq;
      logic [1:0] irq_unit;
      logic [2:0] irq_cc;
      logic [15:0] cache_word;
      logic [15:0] scan_word;
      logic [15:0] last_block;
      logic [RBA_BITS-1:0] relative_block_address;
      logic rba_ecc;
      logic rba_offset;
      logic [15:0] sense12;
      logic [15:0] sense3w;
      logic [15:0] attach_diag;
      logic [15:0] word_out;
   } state_s;

   state_s state_r;
   state_s state_nxt;

   // Binary percent to two BCD digits; 100 uses the ten-digit code.
   function automatic logic [7:0] to_bcd(input logic [6:0] pct);
      logic [6:0] tens;
      logic [6:0] ones;
      begin
         tens = 7'h00;
         ones = pct;
         for (int i = 0; i < 10; i++) begin
            if (ones >= 7'h0a) begin
               ones = ones - 7'h0a;
               tens = tens + 7'h01;
            end
         end
         if (pct >= HIT_RATIO_MAX) begin
            to_bcd = HIT_RATIO_FULL;
         end else begin
            to_bcd = {tens[3:0], ones[3:0]};
         end
      end
   endfunction

   // Permitted code mask of each command class.
   function automatic logic [7:0] allowed(input command_e cmd);
      case (cmd)
         CMD_PREPARE, CMD_READ_ID: allowed = ALLOW_PREPARE;
         CMD_DEVICE_RESET: allowed = ALLOW_RESET;
         CMD_START: allowed = ALLOW_START;
         default: allowed = ALLOW_START;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Next state.
   // ------------------------------------------------------------
   always_comb begin
      logic [7:0] apply;
      logic [7:0] ok;
      logic [2:0] code;
      logic reject;
      logic attn;
      state_nxt = state_r;
      apply = 8'h00;
      ok = 8'h00;
      code = CC_ACCEPTED;
      reject = 1'b0;
      attn = 1'b0;
      state_nxt.cc_valid = 1'b0;
      state_nxt.fetch = 1'b0;

      // Operate I/O: collect applicable codes, mask, pick lowest.
      if (operate_i.valid) begin
         reject = operate_i.block_address[0] || operate_i.command == CMD_INVALID;
         apply[0] = !operate_i.attached;
         apply[1] = state_r.unit[operate_i.unit] == UNIT_BUSY;
         apply[2] = unit_reset_pending_i[operate_i.unit];
         apply[3] = reject;
         apply[5] = operate_i.parity_error;
         apply[6] = controller_busy_i && state_r.active
                    && state_r.active_unit != operate_i.unit;
         apply[7] = 1'b1;
         // Drop codes the command may not give; a rejected request keeps every applicable code.
         ok = apply & (reject ? 8'hff : allowed(operate_i.command));
         for (int i = 7; i >= 0; i--) begin
            if (ok[i]) begin
               code = 3'(i);
            end
         end
         // Code value as even, carry, overflow.
         state_nxt.cc = code;
         state_nxt.cc_valid = 1'b1;
         state_nxt.imm_data = 16'h0000;
         if (code == CC_ACCEPTED) begin
            case (operate_i.command)
               CMD_READ_ID: state_nxt.imm_data = DEVICE_ID;
               CMD_PREPARE: state_nxt.ipl_armed = state_r.ipl_armed;
               CMD_DEVICE_RESET: begin
                  state_nxt.ipl_armed = 1'b0;
                  state_nxt.unit[operate_i.unit] = UNIT_IDLE;
               end
               CMD_START: begin
                  state_nxt.unit[operate_i.unit] = UNIT_BUSY;
                  state_nxt.active = 1'b1;
                  state_nxt.active_unit = operate_i.unit;
                  state_nxt.fetch = 1'b1;
               end
               default: state_nxt.fetch = 1'b0;
            endcase
         end
      end

      // Ending interrupt code from exception and attention.
      if (op_done_i && state_r.active && !state_r.irq) begin
         attn = state_r.ready_seen[state_r.active_unit];
         state_nxt.irq = 1'b1;
         state_nxt.irq_unit = state_r.active_unit;
         state_nxt.not_ready_end[state_r.active_unit] = op_not_ready_i;
         state_nxt.ready_seen[state_r.active_unit] = 1'b0;
         if (op_exception_i) begin
            state_nxt.irq_cc = attn ? ICC_ATTN_EXCEPTION : ICC_EXCEPTION;
         end else begin
            state_nxt.irq_cc = attn ? ICC_ATTN_DEVICE_END : ICC_DEVICE_END;
         end
         state_nxt.active = 1'b0;
      end else if (!state_r.irq && state_r.ipl_armed && operate_i.valid
                   && operate_i.command == CMD_PREPARE && code == CC_ACCEPTED) begin
         state_nxt.irq = 1'b1;
         state_nxt.irq_unit = operate_i.unit;
         state_nxt.irq_cc = ICC_ATTENTION;
         state_nxt.ipl_armed = 1'b0;
      end

      // A fresh load wins over the attention clear in the same cycle.
      if (ipl_done_i) begin
         state_nxt.ipl_armed = 1'b1;
      end

      // A unit ending not ready earns attention when it next returns ready.
      for (int u = 0; u < 4; u++) begin
         if (state_r.not_ready_end[u] && !unit_reset_pending_i[u]
             && state_r.unit[u] == UNIT_IDLE) begin
            state_nxt.ready_seen[u] = 1'b1;
            state_nxt.not_ready_end[u] = 1'b0;
         end
      end

      // Acceptance of the interrupt frees the unit.
      if (interrupt_ack_i && state_r.irq) begin
         state_nxt.irq = 1'b0;
         state_nxt.unit[state_r.irq_unit] = UNIT_IDLE;
      end

      state_nxt.cache_word[15:11] = {cache_scan_i.op_end_int, cache_scan_i.data_ready_int,
                                     cache_scan_i.write_through, cache_scan_i.prefetch,
                                     cache_scan_i.enabled};
      if (cache_scan_i.cache_diag_done) begin
         state_nxt.cache_word[10:8] = cache_scan_i.cache_diag_bits;
      end else begin
         state_nxt.cache_word[10:8] = {cache_scan_i.used, cache_scan_i.total_hit, 1'b1};
      end
      // Hit ratio in BCD or defect marker.
      state_nxt.cache_word[7:0] = cache_scan_i.cache_defect ? HIT_RATIO_CACHE_DEFECT
                                  : to_bcd(cache_scan_i.hit_percent);
      state_nxt.scan_word = {4'h0, cache_scan_i.scan_flags, cache_scan_i.scan_count};

      if (block_used_i) begin
         state_nxt.last_block = block_used_addr_i;
      end

      // ECC record beats head offset beats last access.
      // A new start forgets the old markers; a record in that cycle still sets them, but an old ECC marker still blocks a head offset.
      if (state_nxt.fetch) begin
         state_nxt.rba_ecc = 1'b0;
         state_nxt.rba_offset = 1'b0;
      end
      if (record_i.record_valid) begin
         if (record_i.ecc_invoked) begin
            state_nxt.relative_block_address = record_i.relative_block_address;
            state_nxt.rba_ecc = 1'b1;
         end else if (record_i.head_offset && !state_r.rba_ecc) begin
            state_nxt.relative_block_address = record_i.relative_block_address;
            state_nxt.rba_offset = 1'b1;
         end else if (!state_r.rba_ecc && !state_r.rba_offset) begin
            state_nxt.relative_block_address = record_i.relative_block_address;
         end
      end

      if (diag_i.sense_valid) begin
         // Sense one high, sense two low, bits 4-6 zero.
         // Sense byte one passes as coded by the servo.
         state_nxt.sense12 = {diag_i.sense_one, diag_i.sense_two[7:4],
                              3'h0, diag_i.sense_two[0]};
         // Sense three high, bit 5 unused, wrap low.
         state_nxt.sense3w = {diag_i.sense_three[7:3], 1'b0,
                              diag_i.sense_three[1:0], diag_i.wrap_byte};
         // Detail nibbles replace wrap bits when flagged.
         if (diag_i.interface_error) begin
            state_nxt.sense3w[7:4] = diag_i.interface_detail;
         end
         if (diag_i.timeout_check) begin
            state_nxt.sense3w[3:0] = diag_i.timeout_detail;
         end
         state_nxt.attach_diag = {diag_i.failure_path, diag_i.disabled_pages,
                                  diag_i.error_modifier};
      end

      // Registered status word read, bit 0 of the word is the MSB.
      case (status_index_i)
         WORD_CACHE_INFO: state_nxt.word_out = state_r.cache_word;
         WORD_SCAN_INFO: state_nxt.word_out = state_r.scan_word;
         WORD_LAST_BLOCK: state_nxt.word_out = state_r.last_block;
         WORD_RBA_HIGH: state_nxt.word_out =
            {11'h000, state_r.relative_block_address[RBA_BITS-1 -: RBA_HIGH_BITS]};
         WORD_RBA_LOW: state_nxt.word_out = state_r.relative_block_address[15:0];
         WORD_SENSE_ONE_TWO: state_nxt.word_out = state_r.sense12;
         WORD_SENSE_THREE: state_nxt.word_out = state_r.sense3w;
         WORD_ATTACH_DIAG: state_nxt.word_out = state_r.attach_diag;
         default: state_nxt.word_out = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------
   // Registers.
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= '0;
         state_r.unit <= '{default: UNIT_IDLE};
         state_r.cc <= CC_ACCEPTED;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs.
   assign cc_valid_o = state_r.cc_valid;
   assign condition_code_o = state_r.cc;
   assign immediate_data_o = state_r.imm_data;
   assign fetch_block_o = state_r.fetch;
   assign interrupt_req_o = state_r.irq;
   assign interrupt_unit_o = state_r.irq_unit;
   assign interrupt_cc_o = state_r.irq_cc;
   assign status_word_o = state_r.word_out;
   always_comb begin
      for (int u = 0; u < 4; u++) begin
         unit_busy_o[u] = state_r.unit[u] == UNIT_BUSY;
      end
   end

endmodule

// ===== rtl/disk_status_pkg.sv
package disk_status_pkg;

   // ------------------------------------------------------------
   // Status word indices within the cycle-steal status block.
   // ------------------------------------------------------------
   localparam logic [3:0] WORD_CACHE_INFO = 4'h6;
   localparam logic [3:0] WORD_SCAN_INFO = 4'h7;
   localparam logic [3:0] WORD_LAST_BLOCK = 4'h8;
   localparam logic [3:0] WORD_RBA_HIGH = 4'h9;
   localparam logic [3:0] WORD_RBA_LOW = 4'ha;
   localparam logic [3:0] WORD_SENSE_ONE_TWO = 4'hb;
   localparam logic [3:0] WORD_SENSE_THREE = 4'hc;
   localparam logic [3:0] WORD_ATTACH_DIAG = 4'hd;

   // ------------------------------------------------------------
   // Field constants.
   // ------------------------------------------------------------
   localparam logic [7:0] HIT_RATIO_FULL = 8'ha0;
   localparam logic [7:0] HIT_RATIO_CACHE_DEFECT = 8'hbc;
   localparam logic [6:0] HIT_RATIO_MAX = 7'h64;
   localparam int RBA_HIGH_BITS = 5;
   localparam int RBA_BITS = 21;

   // ------------------------------------------------------------
   // Condition codes, value as even/carry/overflow.
   // ------------------------------------------------------------
   localparam logic [2:0] CC_NOT_ATTACHED = 3'h0;
   localparam logic [2:0] CC_BUSY = 3'h1;
   localparam logic [2:0] CC_BUSY_AFTER_RESET = 3'h2;
   localparam logic [2:0] CC_COMMAND_REJECT = 3'h3;
   localparam logic [2:0] CC_PARITY_CHECK = 3'h5;
   localparam logic [2:0] CC_CONTROLLER_BUSY = 3'h6;
   localparam logic [2:0] CC_ACCEPTED = 3'h7;
   localparam logic [2:0] ICC_EXCEPTION = 3'h2;
   localparam logic [2:0] ICC_DEVICE_END = 3'h3;
   localparam logic [2:0] ICC_ATTENTION = 3'h4;
   localparam logic [2:0] ICC_ATTN_EXCEPTION = 3'h6;
   localparam logic [2:0] ICC_ATTN_DEVICE_END = 3'h7;

   // Permitted code masks, bit n set when code n may appear.
   localparam logic [7:0] ALLOW_PREPARE = 8'ha1;
   localparam logic [7:0] ALLOW_RESET = 8'h81;
   localparam logic [7:0] ALLOW_START = 8'he7;

   // Command classes decoded from the immediate command block.
   typedef enum logic [2:0] {
      CMD_PREPARE = 3'h0,
      CMD_DEVICE_RESET = 3'h1,
      CMD_READ_ID = 3'h2,
      CMD_START = 3'h3,
      CMD_INVALID = 3'h7
   } command_e;

   typedef enum logic [1:0] {
      UNIT_IDLE = 2'b01,
      UNIT_BUSY = 2'b10
   } unit_state_e;

   // Operate I/O request from the channel.
   typedef struct packed {
      logic valid;
      command_e command;
      logic [1:0] unit;
      logic [15:0] block_address;
      logic attached;
      logic parity_error;
   } operate_req_s;

   // Cache and scan facts from the controller.
   typedef struct packed {
      logic op_end_int;
      logic data_ready_int;
      logic write_through;
      logic prefetch;
      logic enabled;
      logic used;
      logic total_hit;
      logic cache_diag_done;
      logic [2:0] cache_diag_bits;
      logic cache_defect;
      logic [6:0] hit_percent;
      logic [3:0] scan_flags;
      logic [7:0] scan_count;
   } cache_scan_s;

   // Record address tracking events.
   typedef struct packed {
      logic record_valid;
      logic ecc_invoked;
      logic head_offset;
      logic [RBA_BITS-1:0] relative_block_address;
   } record_event_s;

   // Disk sense and attachment diagnostics.
   typedef struct packed {
      logic sense_valid;
      logic [7:0] sense_one;
      logic [7:0] sense_two;
      logic [7:0] sense_three;
      logic [7:0] wrap_byte;
      logic timeout_check;
      logic [3:0] timeout_detail;
      logic interface_error;
      logic [3:0] interface_detail;
      logic [2:0] failure_path;
      logic [4:0] disabled_pages;
      logic [7:0] error_modifier;
   } diag_event_s;

endpackage

// ===== dv/disk_status_report_props.sv
`timescale 1ns/1ns
module disk_status_report_props
   import disk_status_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Operate I/O.
   input wire operate_req_s operate_i,
   input wire logic cc_valid_o,
   input wire logic [2:0] condition_code_o,
   input wire logic [15:0] immediate_data_o,
   input wire logic fetch_block_o,
   // Interrupts and status.
   input wire logic interrupt_ack_i,
   input wire logic interrupt_req_o,
   input wire logic [2:0] interrupt_cc_o,
   input wire logic [3:0] status_index_i,
   input wire logic [15:0] status_word_o
);
   // ------------------------------------------------------------
   // Sequences and properties.
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   // Steps of a request, an interrupt handover and a status read.
   sequence s_take;
      operate_i.valid;
   endsequence
   sequence s_ack;
      interrupt_req_o && interrupt_ack_i;
   endsequence
   sequence s_unmapped;
      !(status_index_i inside {[4'h6:4'hd]});
   endsequence

   a_cc_answer: assert property (s_take |=> cc_valid_o)
      else $error("request not answered next cycle");
   a_cc_cause: assert property (cc_valid_o |-> $past(operate_i.valid))
      else $error("answer without a request");
   a_fetch_accept: assert property (fetch_block_o |-> cc_valid_o && condition_code_o == 3'h7)
      else $error("block fetched without acceptance");
   a_not_attached: assert property (s_take ##0 !operate_i.attached |=> condition_code_o == 3'h0)
      else $error("unattached unit not given code zero");
   a_reset_mask: assert property (s_take ##0 operate_i.command == CMD_DEVICE_RESET
      ##0 !operate_i.block_address[0] |=> condition_code_o inside {3'h0, 3'h7})
      else $error("device reset got a forbidden code");
   a_prep_mask: assert property (s_take ##0 operate_i.command inside {CMD_PREPARE, CMD_READ_ID}
      |=> condition_code_o inside {3'h0, 3'h3, 3'h5, 3'h7})
      else $error("prepare or read got a forbidden code");
   a_code_four: assert property (cc_valid_o |-> condition_code_o != 3'h4)
      else $error("unused code four reported");
   a_data_id: assert property (cc_valid_o && condition_code_o != 3'h7 |-> immediate_data_o == 16'h0)
      else $error("identifier given on a refused request");
   a_irq_hold: assert property (interrupt_req_o && !interrupt_ack_i |=> interrupt_req_o)
      else $error("interrupt dropped before acknowledge");
   a_ack_clear: assert property (s_ack |=> !interrupt_req_o)
      else $error("interrupt kept after acknowledge");
   a_irq_code: assert property (interrupt_req_o |-> interrupt_cc_o inside {3'h2, 3'h3, 3'h4, 3'h6, 3'h7})
      else $error("unused interrupt code presented");
   a_unmapped_zero: assert property (s_unmapped |=> status_word_o == 16'h0)
      else $error("unmapped status index not zero");
endmodule

bind disk_status_report disk_status_report_props u_props (.ref_clk_i(ref_clk_i),
   .resetn_i(resetn_i), .operate_i(operate_i), .cc_valid_o(cc_valid_o),
   .condition_code_o(condition_code_o), .immediate_data_o(immediate_data_o),
   .fetch_block_o(fetch_block_o), .interrupt_ack_i(interrupt_ack_i),
   .interrupt_req_o(interrupt_req_o), .interrupt_cc_o(interrupt_cc_o),
   .status_index_i(status_index_i), .status_word_o(status_word_o));

// ===== dv/host_channel_model.sv
`timescale 1ns/1ns
module host_channel_model (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Interrupt handshake.
   input wire logic interrupt_req_i,
   input wire logic slow_i,
   output logic interrupt_ack_o = 1'b0
);
   logic [3:0] wait_cnt = 4'h0;

   // interrupt acceptance
   // The channel takes a pending interrupt after a short or a long wait. It acknowledges
   // only once, since the request may still stand in the cycle after the accepted pulse.
   always @(negedge ref_clk_i) begin
      if (!resetn_i || !interrupt_req_i) begin
         wait_cnt <= 4'h0;
         interrupt_ack_o <= 1'b0;
      end else if (wait_cnt == (slow_i ? 4'h7 : 4'h1)) begin
         interrupt_ack_o <= 1'b1;
         wait_cnt <= 4'hf;
      end else begin
         interrupt_ack_o <= 1'b0;
         wait_cnt <= (wait_cnt == 4'hf) ? wait_cnt : wait_cnt + 4'h1;
      end
   end
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ns
module tb;
   import disk_status_pkg::*;
   // ------------------------------------------------------------
   // Stimulus, instances and shared tasks.
   // ------------------------------------------------------------
   localparam logic [15:0] ID = 16'h3c96;  // Arbitrary identifier value.
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   operate_req_s op = '0;
   cache_scan_s cs = '0;
   record_event_s rec = '0;
   diag_event_s dg = '0;
   logic [3:0] pend = 4'h0;
   logic [3:0] idx = 4'h0;
   logic [15:0] bua = 16'h0;
   logic cbusy = 1'b0, done = 1'b0, exc = 1'b0, initial_program_load = 1'b0, bu = 1'b0, slow = 1'b1;
   logic nr = 1'b0;
   logic ccv, fetch, irq, ack;
   logic [2:0] cc, icc;
   logic [1:0] iu;
   logic [3:0] busy;
   logic [15:0] imm, sw;
   int error_cnt = 0;
   int comparisons = 0;

   disk_status_report #(.DEVICE_ID(ID)) dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .operate_i(op), .unit_reset_pending_i(pend), .controller_busy_i(cbusy),
      .cc_valid_o(ccv), .condition_code_o(cc), .immediate_data_o(imm),
      .fetch_block_o(fetch), .op_done_i(done), .op_exception_i(exc), .op_not_ready_i(nr),
      .interrupt_ack_i(ack), .ipl_done_i(initial_program_load), .interrupt_req_o(irq), .interrupt_unit_o(iu),
      .interrupt_cc_o(icc), .unit_busy_o(busy), .cache_scan_i(cs), .record_i(rec),
      .diag_i(dg), .block_used_i(bu), .block_used_addr_i(bua), .status_index_i(idx),
      .status_word_o(sw));
   host_channel_model host (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .interrupt_req_i(irq), .slow_i(slow), .interrupt_ack_o(ack));

   // The clock toggles every half period of 2 ns.
   initial begin
      forever #2 ref_clk_i = ~ref_clk_i;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // One Operate I/O: valid for one edge, answer looked at in its single cycle.
   task automatic oper(input command_e c, input logic [1:0] u, input logic [15:0] a,
                       input logic att, input logic par, input logic [2:0] exp);
      @(negedge ref_clk_i);
      op = '{1'b1, c, u, a, att, par};
      @(negedge ref_clk_i);
      check("answer", ccv, 16'h1);
      check("code", cc, exp);
      check("fetch", fetch, (c == CMD_START && exp == 3'h7));
      op.valid = 1'b0;
   endtask

   task automatic rd(input logic [3:0] i, input logic [15:0] m, input logic [15:0] exp);
      @(negedge ref_clk_i);
      idx = i;
      @(negedge ref_clk_i);
      check("status word", sw & m, exp);
   endtask

   task automatic record(input logic ecc, input logic ho, input logic [20:0] a);
      @(negedge ref_clk_i);
      rec = '{1'b1, ecc, ho, a};
      @(negedge ref_clk_i);
      rec.record_valid = 1'b0;
   endtask

   // Waits a bounded time for an interrupt, then for the host to take it.
   task automatic irq_seen(input logic [2:0] exp, input logic [1:0] u);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 40) begin
         @(negedge ref_clk_i);
         n++;
      end
      check("irq code", icc, exp);
      check("irq unit", iu, u);
      while (irq === 1'b1 && n < 40) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (n >= 40) begin
         error_cnt++;
         results();
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(negedge ref_clk_i);
      resetn_i = 1'b1;
      check("reset code", cc, CC_ACCEPTED);
      oper(CMD_START, 2'h0, 16'h0100, 1'b1, 1'b0, CC_ACCEPTED);
      check("busy", busy, 16'h1);
      oper(CMD_START, 2'h0, 16'h0100, 1'b1, 1'b0, CC_BUSY);
      cbusy = 1'b1;
      oper(CMD_START, 2'h1, 16'h0200, 1'b1, 1'b0, CC_CONTROLLER_BUSY);
      cbusy = 1'b0;
      oper(CMD_START, 2'h2, 16'h0101, 1'b1, 1'b0, CC_COMMAND_REJECT);
      oper(CMD_INVALID, 2'h2, 16'h0100, 1'b1, 1'b0, CC_COMMAND_REJECT);
      pend = 4'hc;
      oper(CMD_PREPARE, 2'h2, 16'h0100, 1'b0, 1'b1, CC_NOT_ATTACHED);
      oper(CMD_PREPARE, 2'h2, 16'h0100, 1'b1, 1'b1, CC_PARITY_CHECK);
      oper(CMD_PREPARE, 2'h2, 16'h0100, 1'b1, 1'b0, CC_ACCEPTED);
      oper(CMD_DEVICE_RESET, 2'h1, 16'h0100, 1'b1, 1'b1, CC_ACCEPTED);
      oper(CMD_START, 2'h3, 16'h0100, 1'b1, 1'b1, CC_BUSY_AFTER_RESET);
      pend = 4'h0;
      oper(CMD_READ_ID, 2'h2, 16'h0100, 1'b1, 1'b0, CC_ACCEPTED);
      check("identifier", imm, ID);
      check("busy units", busy, 16'h1);
      record(1'b1, 1'b0, 21'h1f1234);
      record(1'b0, 1'b1, 21'h0a5555);
      record(1'b0, 1'b0, 21'h000001);
      rd(WORD_RBA_HIGH, 16'h001f, 16'h001f);
      rd(WORD_RBA_LOW, 16'hffff, 16'h1234);
      done = 1'b1;
      @(negedge ref_clk_i);
      done = 1'b0;
      irq_seen(ICC_DEVICE_END, 2'h0);
      check("busy cleared", busy, 16'h0);
      slow = 1'b0;
      oper(CMD_START, 2'h0, 16'h0300, 1'b1, 1'b0, CC_ACCEPTED);
      record(1'b0, 1'b1, 21'h0a5555);
      record(1'b0, 1'b0, 21'h10beef);
      rd(WORD_RBA_LOW, 16'hffff, 16'h5555);
      done = 1'b1;
      exc = 1'b1;
      nr = 1'b1;
      @(negedge ref_clk_i);
      {done, exc, nr} = 3'h0;
      irq_seen(ICC_EXCEPTION, 2'h0);
      initial_program_load = 1'b1;
      @(negedge ref_clk_i);
      initial_program_load = 1'b0;
      oper(CMD_PREPARE, 2'h1, 16'h0100, 1'b1, 1'b0, CC_ACCEPTED);
      irq_seen(ICC_ATTENTION, 2'h1);
      oper(CMD_START, 2'h0, 16'h0400, 1'b1, 1'b0, CC_ACCEPTED);
      done = 1'b1;
      @(negedge ref_clk_i);
      done = 1'b0;
      irq_seen(ICC_ATTN_DEVICE_END, 2'h0);
      bua = 16'h2468;
      bu = 1'b1;
      @(negedge ref_clk_i);
      bu = 1'b0;
      rd(WORD_LAST_BLOCK, 16'hffff, 16'h2468);
      cs = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 7'd75, 4'h9, 8'h3c};
      rd(WORD_CACHE_INFO, 16'hffff, 16'had75);
      rd(WORD_SCAN_INFO, 16'h0fff, 16'h093c);
      cs.hit_percent = 7'd100;
      rd(WORD_CACHE_INFO, 16'h00ff, 16'h00a0);
      cs.cache_defect = 1'b1;
      rd(WORD_CACHE_INFO, 16'h00ff, 16'h00bc);
      cs.cache_diag_done = 1'b1;
      cs.cache_diag_bits = 3'h2;
      rd(WORD_CACHE_INFO, 16'hff00, 16'haa00);
      dg = '{1'b1, 8'ha5, 8'h9f, 8'hff, 8'ha5, 1'b0, 4'h6, 1'b0, 4'h9, 3'h5, 5'h13, 8'h7e};
      @(negedge ref_clk_i);
      dg.sense_valid = 1'b0;
      rd(WORD_SENSE_ONE_TWO, 16'hffff, 16'ha591);
      rd(WORD_SENSE_THREE, 16'hffff, 16'hfba5);
      rd(WORD_ATTACH_DIAG, 16'hffff, 16'hb37e);
      dg.timeout_check = 1'b1;
      dg.interface_error = 1'b1;
      dg.sense_valid = 1'b1;
      @(negedge ref_clk_i);
      dg.sense_valid = 1'b0;
      rd(WORD_SENSE_THREE, 16'hffff, 16'hfb96);
      rd(4'h3, 16'hffff, 16'h0000);
      rd(4'he, 16'hffff, 16'h0000);
      results();
   end
endmodule
